// [hdl/transfer_engine.sv]
// host buffer transfer engine: AXI4-Lite registers plus a beat request port
// assumes card control supplies mode, trigger and card status on aclk
//
// Behaviour
// - each buffer serves one transfer, invalidated when it ends
// - explicit invalidation stops the engine using the buffer
// - type 1000 sample, 2000 slow auxiliary, 3000 timestamp data
// - direction 0 host-board, 1 board-host, 2 board-gpu, 3 gpu-board
// - direction must suit acquisition or generation unless memory test
// - nonzero notify size: event after each further notify bytes
// - zero notify size: run to the end, then one event
// - board-to-host overwrites host buffer with board memory content
// - outside fifo mode the transfer starts at the board offset
// - exactly the programmed bytes move, within memory size unless in fifo mode or memory test
// - transfer commands and status share the card registers
// - memory test 1 lifts the direction and memory size checks, suspends card commands
// - command bits begin 10000h, wait 20000h, halt 40000h
// - status 100h block, 200h end, 400h overrun, 800h fault
`include "transfer_map.svh"
module transfer_engine (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [17:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [17:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic acq_mode,
  input wire logic trigger_seen,
  input wire logic [7:0] card_status,
  input wire logic fifo_xrun,
  input wire logic mover_fault,
  output logic mover_valid,
  input wire logic mover_ready,
  output logic [2:0] mover_bytes,
  output logic [31:0] mover_board_addr,
  output logic [31:0] mover_host_addr,
  output logic mover_outbound,
  output logic mover_gpu,
  output logic [1:0] mover_source,
  output logic notify_event,
  output logic [15:0] card_cmd,
  output logic card_cmd_valid,
  output logic memory_test_active
);
  transfer_pkg::engine_t q, d;
  logic wr_go;
  logic rd_go;
  logic beat;
  logic inbound;
  logic dir_ok;
  logic type_ok;
  logic len_ok;
  logic [31:0] remain;
  logic [31:0] beat_len;
  logic [31:0] cmd_w;

  // merge a write word into a register under its byte strobes
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        r[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    return r;
  endfunction

  // ==========================================
  // bus handshakes and derived checks
  assign s_axi_awready = !q.aw_have && !q.bvalid;
  assign s_axi_wready = !q.w_have && !q.bvalid;
  assign s_axi_arready = !q.rvalid;
  assign s_axi_bvalid = q.bvalid;
  assign s_axi_bresp = q.bresp;
  assign s_axi_rvalid = q.rvalid;
  assign s_axi_rdata = q.rdata;
  assign s_axi_rresp = q.rresp;
  assign wr_go = q.aw_have && q.w_have && !q.bvalid;
  assign rd_go = s_axi_arvalid && !q.rvalid;
  assign cmd_w = merge(32'h00000000, q.w_data, q.w_strb);
  // directions 0 and 3 fill board memory, 1 and 2 drain it
  assign inbound = (q.dir == `DIR_HOST_TO_BOARD) || (q.dir == `DIR_GPU_TO_BOARD);
  // memory test lifts the mode check
  assign dir_ok = q.memtest || (acq_mode ? !inbound : inbound);
  // only the three documented type codes select a source
  assign type_ok = (q.buf_type == `TYPE_SAMPLE) || (q.buf_type == `TYPE_AUX) || (q.buf_type == `TYPE_STAMP);
  // standard mode may not ask for more than memory size
  assign len_ok = (q.length != 32'h00000000) && (q.fifo_mode || q.memtest || q.length <= q.memsize);
  assign remain = q.length - q.moved;
  assign beat_len = (remain < `BEAT_BYTES) ? remain : `BEAT_BYTES;
  assign beat = mover_valid && mover_ready;

  // ==========================================
  // beat request port, addresses come from flops
  assign mover_valid = (q.st == transfer_pkg::S_RUN);
  assign mover_bytes = beat_len[2:0]; // last beat may be short
  assign mover_board_addr = q.cur_board;
  assign mover_host_addr = q.cur_host;
  assign mover_outbound = !inbound; // board-to-host overwrites host data
  assign mover_gpu = q.dir[1];
  assign mover_source = (q.buf_type == `TYPE_AUX) ? 2'h1 : (q.buf_type == `TYPE_STAMP) ? 2'h2 : 2'h0;
  assign notify_event = q.notify_event;
  assign card_cmd = q.card_cmd;
  assign card_cmd_valid = q.card_cmd_valid;
  assign memory_test_active = q.memtest;

  // ==========================================
  // next state of the whole engine
  always_comb begin
    d = q;
    d.notify_event = 1'b0;
    d.card_cmd_valid = 1'b0;
    // write address and data are taken in either order
    if (s_axi_awvalid && s_axi_awready) begin
      d.aw_have = 1'b1;
      d.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      d.w_have = 1'b1;
      d.w_data = s_axi_wdata;
      d.w_strb = s_axi_wstrb;
    end
    if (q.bvalid && s_axi_bready) begin
      d.bvalid = 1'b0;
    end
    if (q.rvalid && s_axi_rready) begin
      d.rvalid = 1'b0;
    end
    // register reads; status flags clear on read, later sets still win
    if (rd_go) begin
      d.rvalid = 1'b1;
      d.rresp = `RESP_OKAY;
      d.rdata = 32'h00000000;
      case (s_axi_araddr)
        `OFS_CMD: d.rdata = 32'h00000000;
        `OFS_STATUS: begin
          d.rdata[7:0] = card_status; // shared with card control
          d.rdata[`ST_BLOCK] = q.st_block;
          d.rdata[`ST_END] = q.st_end;
          d.rdata[`ST_XRUN] = q.st_xrun;
          d.rdata[`ST_FAULT] = q.st_fault;
          d.rdata[`ST_WAITING] = q.waiting;
          d.rdata[`ST_BUFVALID] = q.buf_valid;
          d.rdata[`ST_RUNNING] = (q.st != transfer_pkg::S_IDLE);
          d.st_block = 1'b0;
          d.st_end = 1'b0;
          d.st_xrun = 1'b0;
          d.st_fault = 1'b0;
        end
        `OFS_BUF_TYPE: d.rdata = q.buf_type;
        `OFS_DIR: d.rdata = {30'h00000000, q.dir};
        `OFS_NOTIFY: d.rdata = q.notify;
        `OFS_HOST_PTR: d.rdata = q.host_ptr;
        `OFS_BRD_OFS: d.rdata = q.brd_ofs;
        `OFS_LENGTH: d.rdata = q.length;
        `OFS_MEMSIZE: d.rdata = q.memsize;
        `OFS_MODE: d.rdata = {31'h00000000, q.fifo_mode};
        `OFS_INVALIDATE: d.rdata = 32'h00000000;
        `OFS_MEMTEST: d.rdata = {31'h00000000, q.memtest};
        default: d.rresp = `RESP_DECERR;
      endcase
    end
    // register writes; buffer fields only change while idle
    if (wr_go) begin
      d.aw_have = 1'b0;
      d.w_have = 1'b0;
      d.bvalid = 1'b1;
      d.bresp = `RESP_OKAY;
      case (q.aw_addr)
        `OFS_CMD: begin
          // card command bits pass on unless memory test holds them
          if (!q.memtest && (cmd_w[15:0] != 16'h0000)) begin
            d.card_cmd = cmd_w[15:0];
            d.card_cmd_valid = 1'b1;
          end
          if (cmd_w[`CMD_HALT]) begin
            // halt drops the buffer, its data is void
            d.st = transfer_pkg::S_IDLE;
            d.buf_valid = 1'b0;
            d.waiting = 1'b0;
          end else if (cmd_w[`CMD_BEGIN] && q.buf_valid && q.st == transfer_pkg::S_IDLE) begin
            // no valid buffer means the begin is dropped
            if (!(dir_ok && type_ok && len_ok)) begin
              d.st_fault = 1'b1;
              d.buf_valid = 1'b0;
            end else begin
              // offset ignored in fifo mode
              d.cur_board = q.fifo_mode ? 32'h00000000 : q.brd_ofs;
              d.cur_host = q.host_ptr;
              d.moved = 32'h00000000;
              d.notify_cnt = 32'h00000000;
              // during acquisition the begin waits for the trigger
              d.st = (acq_mode && !trigger_seen) ? transfer_pkg::S_ARMED : transfer_pkg::S_RUN;
            end
          end
          if (cmd_w[`CMD_WAIT] && !cmd_w[`CMD_HALT]) begin
            d.waiting = 1'b1;
          end
        end
        `OFS_BUF_TYPE: if (q.st == transfer_pkg::S_IDLE) d.buf_type = merge(q.buf_type, q.w_data, q.w_strb);
        `OFS_DIR: if (q.st == transfer_pkg::S_IDLE && q.w_strb[0]) d.dir = q.w_data[1:0];
        `OFS_NOTIFY: if (q.st == transfer_pkg::S_IDLE) d.notify = merge(q.notify, q.w_data, q.w_strb);
        `OFS_HOST_PTR: if (q.st == transfer_pkg::S_IDLE) d.host_ptr = merge(q.host_ptr, q.w_data, q.w_strb);
        `OFS_BRD_OFS: if (q.st == transfer_pkg::S_IDLE) d.brd_ofs = merge(q.brd_ofs, q.w_data, q.w_strb);
        `OFS_LENGTH: begin
          // writing the length completes a definition
          if (q.st == transfer_pkg::S_IDLE) begin
            d.length = merge(q.length, q.w_data, q.w_strb);
            d.buf_valid = 1'b1;
          end
        end
        `OFS_MEMSIZE: d.memsize = merge(q.memsize, q.w_data, q.w_strb);
        `OFS_MODE: if (q.w_strb[0]) d.fifo_mode = q.w_data[0];
        `OFS_INVALIDATE: begin
          // explicit release stops any use of the buffer
          d.st = transfer_pkg::S_IDLE;
          d.buf_valid = 1'b0;
          d.waiting = 1'b0;
        end
        `OFS_MEMTEST: if (q.w_strb[0]) d.memtest = q.w_data[0];
        default: d.bresp = `RESP_DECERR;
      endcase
    end
    // transfer sequencing; a halt or release in this cycle takes priority
    case (q.st)
      transfer_pkg::S_IDLE: begin
      end
      transfer_pkg::S_ARMED: begin
        if (d.st == transfer_pkg::S_ARMED && trigger_seen) begin
          d.st = transfer_pkg::S_RUN;
        end
      end
      transfer_pkg::S_RUN: begin
        if (d.st == transfer_pkg::S_RUN && mover_fault) begin
          d.st_fault = 1'b1;
          d.st = transfer_pkg::S_IDLE;
          d.buf_valid = 1'b0;
          d.waiting = 1'b0;
        end else if (d.st == transfer_pkg::S_RUN && beat) begin
          d.moved = q.moved + beat_len;
          d.cur_board = q.cur_board + beat_len;
          d.cur_host = q.cur_host + beat_len;
          d.notify_cnt = q.notify_cnt + beat_len;
          // one event per notify block
          if (q.notify != 32'h00000000 && d.notify_cnt >= q.notify) begin
            d.notify_cnt = d.notify_cnt - q.notify;
            d.st_block = 1'b1;
            d.notify_event = 1'b1;
            d.waiting = 1'b0;
          end
          if (d.moved == q.length) begin
            // buffer is spent after one use
            d.st = transfer_pkg::S_IDLE;
            d.buf_valid = 1'b0;
            d.waiting = 1'b0;
            d.notify_event = 1'b1;
            if (q.notify == 32'h00000000) begin
              d.st_end = 1'b1; // single event at the end
            end else begin
              d.st_block = 1'b1; // residue shows as a final block
            end
          end
        end
      end
      default: d.st = transfer_pkg::S_IDLE;
    endcase
    if (fifo_xrun) begin
      d.st_xrun = 1'b1;
    end
  end

  // ==========================================
  // state register, synchronous reset
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      q <= '0;
      q.st <= transfer_pkg::S_IDLE;
    end else begin
      q <= d;
    end
  end
endmodule

// [hdl/transfer_map.svh]
// register map, field positions and codes of the transfer engine
// assumes byte addresses on an 18-bit AXI4-Lite address
`ifndef TRANSFER_MAP_SVH
`define TRANSFER_MAP_SVH
// ==========================================
// register byte offsets
`define OFS_CMD 18'h00000
`define OFS_STATUS 18'h00004
`define OFS_BUF_TYPE 18'h00008
`define OFS_DIR 18'h0000C
`define OFS_NOTIFY 18'h00010
`define OFS_HOST_PTR 18'h00014
`define OFS_BRD_OFS 18'h00018
`define OFS_LENGTH 18'h0001C
`define OFS_MEMSIZE 18'h00020
`define OFS_MODE 18'h00024
`define OFS_INVALIDATE 18'h00028
`define OFS_MEMTEST 18'h30FFC
// ==========================================
// command and status bits
`define CMD_BEGIN 16
`define CMD_WAIT 17
`define CMD_HALT 18
`define ST_BLOCK 8
`define ST_END 9
`define ST_XRUN 10
`define ST_FAULT 11
`define ST_WAITING 12
`define ST_BUFVALID 13
`define ST_RUNNING 14
// ==========================================
// buffer type and direction codes
`define TYPE_SAMPLE 32'h000003E8
`define TYPE_AUX 32'h000007D0
`define TYPE_STAMP 32'h00000BB8
`define DIR_HOST_TO_BOARD 2'h0
`define DIR_BOARD_TO_HOST 2'h1
`define DIR_BOARD_TO_GPU 2'h2
`define DIR_GPU_TO_BOARD 2'h3
`define BEAT_BYTES 32'h00000004
`define RESP_OKAY 2'h0
`define RESP_DECERR 2'h3
`endif

// [hdl/transfer_pkg.sv]
// types of the transfer engine
// assumes the engine holds all its state in one packed struct
package transfer_pkg;
  typedef enum logic [1:0] {S_IDLE, S_ARMED, S_RUN} xfer_state_t;
  typedef struct packed {
    xfer_state_t st;
    logic aw_have;
    logic [17:0] aw_addr;
    logic w_have;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic [31:0] memsize;
    logic [31:0] buf_type;
    logic [1:0] dir;
    logic [31:0] notify;
    logic [31:0] host_ptr;
    logic [31:0] brd_ofs;
    logic [31:0] length;
    logic fifo_mode;
    logic memtest;
    logic buf_valid;
    logic st_block;
    logic st_end;
    logic st_xrun;
    logic st_fault;
    logic waiting;
    logic [31:0] moved;
    logic [31:0] notify_cnt;
    logic [31:0] cur_board;
    logic [31:0] cur_host;
    logic [15:0] card_cmd;
    logic card_cmd_valid;
    logic notify_event;
  } engine_t;
endpackage

// [verif/transfer_engine_props.sv]
// checker of the transfer engine: beat port and card command strobe
// assumes one clock aclk and a synchronous active-low aresetn
module transfer_engine_props (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic mover_valid,
  input wire logic mover_ready,
  input wire logic [2:0] mover_bytes,
  input wire logic [31:0] mover_board_addr,
  input wire logic [31:0] mover_host_addr,
  input wire logic [1:0] mover_source,
  input wire logic mover_fault,
  input wire logic notify_event,
  input wire logic card_cmd_valid,
  input wire logic memory_test_active
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  // ==========================================
  // beat port
  wire logic beat = mover_valid && mover_ready;
  a_source_code: assert property (mover_valid |-> mover_source != 2'h3)
    else $error("source code out of range");
  a_beat_size: assert property (mover_valid |-> mover_bytes != 3'h0 && mover_bytes <= 3'h4)
    else $error("beat size out of range");
  a_board_step: assert property (beat |=> !mover_valid || mover_board_addr == $past(mover_board_addr) + 32'h4)
    else $error("board address did not step by a word");
  a_host_step: assert property (beat |=> !mover_valid || mover_host_addr == $past(mover_host_addr) + 32'h4)
    else $error("host address did not step by a word");
  // a stalled beat keeps its address, or the far side would lose data
  a_stall_hold: assert property (mover_valid && !mover_ready && !mover_fault |=> !mover_valid || $stable(mover_board_addr))
    else $error("address moved while stalled");
  a_fault_abort: assert property (mover_valid && mover_fault |=> !mover_valid)
    else $error("fault did not stop the transfer");
  a_event_cause: assert property (notify_event |-> $past(beat))
    else $error("notify event without a moved beat");
  // ==========================================
  // card commands
  a_cmd_pulse: assert property (card_cmd_valid |=> !card_cmd_valid)
    else $error("card command strobe longer than one cycle");
  a_memtest_cmd: assert property (card_cmd_valid |-> !memory_test_active)
    else $error("card command passed during memory test");
  c_event: cover property (notify_event);
  c_stall: cover property (mover_valid && !mover_ready);
  c_fault: cover property (mover_valid && mover_fault);
endmodule
bind transfer_engine transfer_engine_props chk_u (.aclk, .aresetn, .mover_valid, .mover_ready, .mover_bytes,
  .mover_board_addr, .mover_host_addr, .mover_source, .mover_fault, .notify_event, .card_cmd_valid,
  .memory_test_active);

// [verif/mover_far.sv]
// far-side model of the beat port: a memory mover that may stall
// assumes beats hand over on the rising edge of aclk
module mover_far (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic slow,
  input wire logic mover_valid,
  input wire logic [2:0] mover_bytes,
  input wire logic [31:0] mover_board_addr,
  output logic mover_ready,
  output logic [31:0] moved,
  output logic [31:0] first_addr
);
  timeunit 1ns;
  timeprecision 1ps;
  logic was_valid;
  // ==========================================
  // stall every other cycle when slow; tally bytes, note where each run starts
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mover_ready <= 1'h0;
      moved <= '0;
      first_addr <= '0;
      was_valid <= 1'h0;
    end else begin
      mover_ready <= slow ? !mover_ready : 1'h1;
      was_valid <= mover_valid;
      if (mover_valid && !was_valid) first_addr <= mover_board_addr;
      if (mover_valid && mover_ready) moved <= moved + {29'h0, mover_bytes};
    end
  end
endmodule

// [verif/transfer_engine_tb.sv]
// bench of the transfer engine: table of buffer definitions, then corner cases
// assumes transfer_map.svh on the include path and mover_far on the beat port
`include "transfer_map.svh"
`define CHK(n, e, g) begin checks++; if ((g) !== (e)) begin mismatches++; \
  $display("BAD %s exp %0h got %0h", n, e, g); end end
module transfer_engine_tb;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct {
    logic [31:0] ty;
    logic [1:0] dir;
    logic acq;
    logic [31:0] nfy, ofs, len;
    logic [14:0] st;
    logic [31:0] mv, ev;
  } row_t;
  logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, acq_mode, trigger_seen, mover_fault, slow;
  logic mover_valid, mover_ready, notify_event, card_cmd_valid, memory_test_active, fifo_xrun, mover_outbound;
  logic mover_gpu;
  logic [17:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, mover_board_addr, mover_host_addr, moved, first_addr, ev, cc, d, m0, c0;
  logic [1:0] s_axi_bresp, s_axi_rresp, mover_source, r;
  logic [2:0] mover_bytes;
  logic [15:0] card_cmd;
  int mismatches, checks;
  // status holds card bits 5A plus block 100h, end 200h or fault 800h
  row_t rows[10] = '{
    '{`TYPE_SAMPLE, 2'h1, 1'h1, 32'h0, 32'h40, 32'h10, 15'h25A, 32'h10, 32'h1},
    '{`TYPE_SAMPLE, 2'h1, 1'h1, 32'h10, 32'h0, 32'h1E, 15'h15A, 32'h1E, 32'h2},
    '{`TYPE_AUX, 2'h2, 1'h1, 32'h800, 32'h8, 32'h4, 15'h15A, 32'h4, 32'h1},
    '{`TYPE_STAMP, 2'h1, 1'h1, 32'h800, 32'h0, 32'h8, 15'h15A, 32'h8, 32'h1},
    '{`TYPE_SAMPLE, 2'h0, 1'h0, 32'h0, 32'h80, 32'h8, 15'h25A, 32'h8, 32'h1},
    '{`TYPE_SAMPLE, 2'h3, 1'h0, 32'h0, 32'h0, 32'h100, 15'h25A, 32'h100, 32'h1},
    '{`TYPE_SAMPLE, 2'h0, 1'h1, 32'h0, 32'h0, 32'h8, 15'h85A, 32'h0, 32'h0},
    '{`TYPE_SAMPLE, 2'h1, 1'h0, 32'h0, 32'h0, 32'h8, 15'h85A, 32'h0, 32'h0},
    '{32'h4D2, 2'h1, 1'h1, 32'h0, 32'h0, 32'h8, 15'h85A, 32'h0, 32'h0},
    '{`TYPE_SAMPLE, 2'h1, 1'h1, 32'h0, 32'h0, 32'h104, 15'h85A, 32'h0, 32'h0}};
  transfer_engine dut_u (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awprot(3'h0), .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb(4'hF), .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arprot(3'h0), .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .acq_mode, .trigger_seen, .card_status(8'h5A), .fifo_xrun,
    .mover_fault, .mover_valid, .mover_ready, .mover_bytes, .mover_board_addr, .mover_host_addr,
    .mover_outbound, .mover_gpu, .mover_source, .notify_event, .card_cmd, .card_cmd_valid,
    .memory_test_active);
  mover_far far_u (.aclk, .aresetn, .slow, .mover_valid, .mover_bytes, .mover_board_addr, .mover_ready, .moved,
    .first_addr);
  // ==========================================
  // clock, event counters, watchdog
  initial begin
    aclk = 1'h0;
    forever #20 aclk = ~aclk;
  end
  // counters skip reset edges, where the outputs may still be unknown
  always @(posedge aclk) begin
    if (aresetn) begin
      ev <= ev + {31'h0, notify_event};
      cc <= cc + {31'h0, card_cmd_valid};
    end
  end
  initial begin
    repeat (20000) @(posedge aclk);
    mismatches++;
    conclude();
  end
  task automatic conclude;
    if (mismatches == 0 && checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // ==========================================
  // bus tasks: hold each channel until its ready, the answer ends the task
  task automatic wr(input logic [17:0] a, input logic [31:0] v);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    do begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'h0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'h0;
      if (s_axi_bvalid && s_axi_bready) s_axi_bready <= 1'h0;
    end while (s_axi_bready);
  endtask
  task automatic rd(input logic [17:0] a, output logic [31:0] v, output logic [1:0] p);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    do begin
      @(posedge aclk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'h0;
      if (s_axi_rvalid && s_axi_rready) begin
        v = s_axi_rdata;
        p = s_axi_rresp;
        s_axi_rready <= 1'h0;
      end
    end while (s_axi_rready);
  endtask
  task automatic st(input logic [14:0] e);
    logic [31:0] v;
    logic [1:0] p;
    rd(`OFS_STATUS, v, p);
    `CHK("status", e, v[14:0])
  endtask
  // host pointer stays page aligned; length is written last since it commits
  task automatic def(input logic [31:0] ty, input logic [1:0] dr, input logic [31:0] nf, of, ln);
    wr(`OFS_BUF_TYPE, ty);
    wr(`OFS_DIR, {30'h0, dr});
    wr(`OFS_NOTIFY, nf);
    wr(`OFS_HOST_PTR, 32'h1000);
    wr(`OFS_BRD_OFS, of);
    wr(`OFS_LENGTH, ln);
  endtask
  task automatic settle;
    int n;
    n = 0;
    repeat (3) @(posedge aclk);
    while (mover_valid && n < 400) begin
      @(posedge aclk);
      n++;
    end
    @(posedge aclk);
  endtask
  task automatic run_row(input row_t w);
    logic [31:0] b, e;
    acq_mode <= w.acq;
    def(w.ty, w.dir, w.nfy, w.ofs, w.len);
    b = moved;
    e = ev;
    wr(`OFS_CMD, 32'h10000);
    settle();
    `CHK("moved", w.mv, moved - b)
    `CHK("events", w.ev, ev - e)
    if (w.mv != 32'h0) `CHK("start", w.ofs, first_addr)
    st(w.st);
  endtask
  // ==========================================
  // main sequence
  initial begin
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready, acq_mode, mover_fault, slow} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, ev, cc} = '0;
    fifo_xrun = 1'h0;
    aresetn = 1'h0;
    trigger_seen = 1'h1;
    repeat (10) @(posedge aclk);
    aresetn <= 1'h1;
    rd(`OFS_MEMTEST, d, r);
    `CHK("memtest reset", 32'h0, d)
    // memory size comes before any definition; fifo mode and memory test are set later
    wr(`OFS_MEMSIZE, 32'h100);
    foreach (rows[i]) begin
      slow <= i[0];
      run_row(rows[i]);
    end
    // begin with no buffer left must do nothing
    m0 = moved;
    wr(`OFS_CMD, 32'h10000);
    settle();
    `CHK("no buffer", m0, moved)
    st(15'h05A);
    // start waits for the trigger during acquisition
    trigger_seen <= 1'h0;
    def(`TYPE_SAMPLE, 2'h1, 32'h0, 32'h0, 32'h8);
    m0 = moved;
    wr(`OFS_CMD, 32'h10000);
    repeat (6) @(posedge aclk);
    `CHK("armed", 1'h0, mover_valid)
    `CHK("route", 4'h8, {mover_outbound, mover_gpu, mover_source})
    `CHK("host start", 32'h1000, mover_host_addr)
    trigger_seen <= 1'h1;
    settle();
    `CHK("after trigger", 32'h8, moved - m0)
    st(15'h25A);
    // halt, then explicit invalidation, in mid transfer
    slow <= 1'h1;
    for (int k = 0; k < 2; k++) begin
      def(`TYPE_SAMPLE, 2'h1, 32'h0, 32'h0, 32'h40);
      m0 = moved;
      wr(`OFS_CMD, 32'h10000);
      wr(k ? `OFS_INVALIDATE : `OFS_CMD, 32'h40000);
      settle();
      `CHK("cut short", 1'h1, (moved - m0) < 32'h40)
      st(15'h05A);
    end
    // wait flag while running, then a fault from the mover
    def(`TYPE_SAMPLE, 2'h1, 32'h0, 32'h0, 32'h40);
    wr(`OFS_CMD, 32'h30000);
    st(15'h705A);
    settle();
    st(15'h25A);
    def(`TYPE_SAMPLE, 2'h1, 32'h0, 32'h0, 32'h40);
    wr(`OFS_CMD, 32'h10000);
    mover_fault <= 1'h1;
    @(posedge aclk);
    mover_fault <= 1'h0;
    settle();
    st(15'h85A);
    // memory test lifts the direction check and holds back card commands
    wr(`OFS_MEMTEST, 32'h1);
    rd(`OFS_MEMTEST, d, r);
    `CHK("memtest read", 32'h1, d)
    `CHK("memtest pin", 1'h1, memory_test_active)
    c0 = cc;
    wr(`OFS_CMD, 32'h3);
    `CHK("held cmd", c0, cc)
    run_row(row_t'{`TYPE_SAMPLE, 2'h0, 1'h1, 32'h0, 32'h20, 32'h8, 15'h25A, 32'h8, 32'h1});
    wr(`OFS_MEMTEST, 32'h0);
    `CHK("memtest off", 1'h0, memory_test_active)
    wr(`OFS_CMD, 32'h3);
    `CHK("card cmd", 16'h3, card_cmd)
    `CHK("card pulses", c0 + 32'h1, cc)
    // fifo mode lifts the memory size limit on the length
    wr(`OFS_MODE, 32'h1);
    run_row(row_t'{`TYPE_SAMPLE, 2'h1, 1'h1, 32'h0, 32'h0, 32'h104, 15'h25A, 32'h104, 32'h1});
    wr(`OFS_MODE, 32'h0);
    rd(18'h00100, d, r);
    `CHK("unmapped resp", `RESP_DECERR, r)
    `CHK("unmapped data", 32'h0, d)
    // overrun is sticky; a set in the cycle of the read beats the clear
    fifo_xrun <= 1'h1;
    st(15'h45A);
    st(15'h45A);
    fifo_xrun <= 1'h0;
    st(15'h45A);
    st(15'h05A);
    // reset in mid transfer stops the beats and forgets buffer and memory size
    def(`TYPE_SAMPLE, 2'h1, 32'h0, 32'h0, 32'h40);
    wr(`OFS_CMD, 32'h10000);
    aresetn <= 1'h0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'h1;
    @(posedge aclk);
    `CHK("reset beats", 1'h0, mover_valid)
    st(15'h05A);
    rd(`OFS_MEMSIZE, d, r);
    `CHK("reset memsize", 32'h0, d)
    conclude();
  end
endmodule
